// ### core/pspsm_port_slot.sv
`timescale 1ns/1ps
// One port: result fields, power flags and start-fault flag
module pspsm_port_slot
  import pspsm_pkg::*;
(
  // Clock and reset
  input  wire logic       i_clk,
  input  wire logic       i_sys_rst,
  // Measurement events
  input  wire logic       i_det_valid,
  input  wire logic [3:0] i_det_code,
  input  wire logic       i_legacy,
  input  wire logic       i_cls1_valid,
  input  wire logic [3:0] i_cls1_code,
  input  wire logic       i_cls2_valid,
  input  wire logic [3:0] i_cls2_code,
  input  wire logic       i_two_event,
  // Power sequencing
  input  wire logic       i_turn_on,
  input  wire logic       i_turn_off,
  input  wire logic       i_on_done,
  input  wire logic       i_drain_good,
  // Start-fault clear by read
  input  wire logic       i_strt_clear,
  // Outputs
  output logic [3:0]      o_class_reg,
  output logic [3:0]      o_detect_reg,
  output logic            o_pon_reg,
  output logic            o_pgood_reg,
  output logic            o_strt_reg,
  output logic            o_cls_fault_reg
);
  import pspsm_pkg::*;

  logic [3:0] cls1_reg;        // First classification outcome
  logic       cls1_seen_reg;   // First event taken, second pending
  logic       det_accept;      // Detection code legal for this mode
  logic       cls_fault;       // Classification ended in a fault

  // Legacy codes only come from legacy detection
  assign det_accept = i_det_valid && (i_legacy || i_det_code < DET_LEGACY_LO);

  // Fault outcome of a finished classification
  always_comb begin
    cls_fault = 1'b0;
    if (i_cls1_valid && i_cls1_code == CLS_OVERCUR) begin
      cls_fault = 1'b1;
    end else if (i_cls2_valid && cls1_seen_reg) begin
      cls_fault = (i_cls2_code == CLS_OVERCUR) || (i_cls2_code != cls1_reg);
    end
  end

  // Detection result; turn-off wins since results belong to the old session
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_detect_reg <= 4'h0;
    end else if (i_turn_off) begin
      o_detect_reg <= DET_UNKNOWN;
    end else if (det_accept) begin
      o_detect_reg <= i_det_code;
    end
  end

  // Classification result with two-event merge
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_class_reg   <= 4'h0;
      cls1_reg      <= 4'h0;
      cls1_seen_reg <= 1'b0;
    end else if (i_turn_off) begin
      o_class_reg   <= CLS_UNKNOWN;
      cls1_seen_reg <= 1'b0;
    end else if (i_cls1_valid) begin
      // Reserved code reads back as class 0
      o_class_reg   <= (i_cls1_code == CLS_RSVD5) ? CLS_CLASS0 : i_cls1_code;
      cls1_reg      <= i_cls1_code;
      // Overcurrent on the first event blocks any second event
      cls1_seen_reg <= i_two_event && (i_cls1_code != CLS_OVERCUR);
    end else if (i_cls2_valid && cls1_seen_reg) begin
      cls1_seen_reg <= 1'b0;
      if (i_cls2_code == CLS_OVERCUR) begin
        o_class_reg <= CLS_OVERCUR;
      end else if (i_cls2_code != cls1_reg) begin
        o_class_reg <= CLS_MISMATCH;
      end else begin
        o_class_reg <= (i_cls2_code == CLS_RSVD5) ? CLS_CLASS0 : i_cls2_code;
      end
    end
  end

  // Power flags: off clears both, good latches after turn-on completes
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_pon_reg   <= 1'b0;
      o_pgood_reg <= 1'b0;
    end else if (i_turn_off) begin
      o_pon_reg   <= 1'b0;
      o_pgood_reg <= 1'b0;
    end else begin
      if (i_turn_on) begin
        o_pon_reg <= 1'b1;
      end
      if (o_pon_reg && i_on_done && i_drain_good) begin
        o_pgood_reg <= 1'b1;
      end
    end
  end

  // Start-fault flag and auto-power inhibit; set wins over read clear.
  // The inhibit also stands while a second event is pending, so that
  // auto mode cannot power the port on half a classification.
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_strt_reg      <= 1'b0;
      o_cls_fault_reg <= 1'b0;
    end else begin
      if (cls_fault) begin
        o_strt_reg <= 1'b1;
      end else if (i_strt_clear || i_turn_off) begin
        o_strt_reg <= 1'b0;
      end
      if (cls_fault) begin
        o_cls_fault_reg <= 1'b1;
      end else if (i_turn_off) begin
        o_cls_fault_reg <= 1'b0;
      end else if (i_cls1_valid) begin
        // Pending second event holds auto power off
        o_cls_fault_reg <= i_two_event;
      end else if (i_cls2_valid && cls1_seen_reg) begin
        // Clean second event ends the hold
        o_cls_fault_reg <= 1'b0;
      end
    end
  end

  // Mismatch is reported when the two outcomes differ and the second is not overcurrent
  property p_mismatch;
    @(posedge i_clk) disable iff (i_sys_rst)
      (i_cls2_valid && cls1_seen_reg && !i_cls1_valid && !i_turn_off &&
       i_cls2_code != CLS_OVERCUR && i_cls2_code != cls1_reg) |=> (o_class_reg == CLS_MISMATCH);
  endproperty
  a_mismatch: assert property (p_mismatch) else $error("mismatch not reported");

  // First overcurrent ends classification
  property p_oc_first;
    @(posedge i_clk) disable iff (i_sys_rst)
      (i_cls1_valid && !i_turn_off && i_cls1_code == CLS_OVERCUR) |=>
        (o_class_reg == CLS_OVERCUR && !cls1_seen_reg);
  endproperty
  a_oc_first: assert property (p_oc_first) else $error("overcurrent not final");

  // Classification fault raises the start flag
  property p_strt;
    @(posedge i_clk) disable iff (i_sys_rst)
      cls_fault |=> o_strt_reg && o_cls_fault_reg;
  endproperty
  a_strt: assert property (p_strt) else $error("start fault flag missing");

  // Turn-off clears results and power flags
  property p_off;
    @(posedge i_clk) disable iff (i_sys_rst)
      i_turn_off |=> (o_class_reg == 4'h0 && o_detect_reg == 4'h0 && !o_pon_reg && !o_pgood_reg);
  endproperty
  a_off: assert property (p_off) else $error("turn-off did not clear");

  // Power good never stands without power on
  property p_pg;
    @(posedge i_clk) disable iff (i_sys_rst)
      o_pgood_reg |-> o_pon_reg;
  endproperty
  a_pg: assert property (p_pg) else $error("power good without power on");

  // Legacy codes stay out without legacy detection
  property p_legacy;
    @(posedge i_clk) disable iff (i_sys_rst)
      (i_det_valid && !i_legacy && i_det_code >= DET_LEGACY_LO) |=> $stable(o_detect_reg) || o_detect_reg == 4'h0;
  endproperty
  a_legacy: assert property (p_legacy) else $error("legacy code without legacy detect");

endmodule // pspsm_port_slot

// ### core/pspsm_regs.sv
`timescale 1ns/1ps
module pspsm_regs
  import pspsm_pkg::*;
(
  // Clock and reset
  input  wire logic                   i_clk,
  input  wire logic                   i_sys_rst,
  // Nonvolatile address and standalone bit
  input  wire logic [6:0]             i_nv_bus_device_address,
  input  wire logic                   i_nv_standalone,
  // Command access from the bus engine
  input  wire logic                   i_wr,
  input  wire logic                   i_rd,
  input  wire logic [CMD_W-1:0]       i_cmd,
  input  wire logic [DATA_W-1:0]      i_wdata,
  // Per-port measurement events
  input  wire logic [NUM_PORTS-1:0]   i_det_valid,
  input  wire logic [4*NUM_PORTS-1:0] i_det_code,
  input  wire logic [NUM_PORTS-1:0]   i_legacy,
  input  wire logic [NUM_PORTS-1:0]   i_cls1_valid,
  input  wire logic [4*NUM_PORTS-1:0] i_cls1_code,
  input  wire logic [NUM_PORTS-1:0]   i_cls2_valid,
  input  wire logic [4*NUM_PORTS-1:0] i_cls2_code,
  input  wire logic [NUM_PORTS-1:0]   i_two_event,
  // Per-port power sequencing
  input  wire logic [NUM_PORTS-1:0]   i_host_power_on,
  input  wire logic [NUM_PORTS-1:0]   i_turn_off,
  input  wire logic [NUM_PORTS-1:0]   i_on_done,
  input  wire logic [NUM_PORTS-1:0]   i_drain_good,
  // Read data
  output logic [DATA_W-1:0]           o_rdata,
  // Port control toward the power stage
  output logic [2*NUM_PORTS-1:0]      o_modes,
  output logic [2*NUM_PORTS-1:0]      o_dc_enable,
  output logic [NUM_PORTS-1:0]        o_auto_det_cls,
  output logic [NUM_PORTS-1:0]        o_power_request
);
  import pspsm_pkg::*;

  logic [7:0]           modes_reg;      // Operating mode fields
  logic [7:0]           dcen_reg;       // Class / detect enable bits
  logic [7:0]           addr_reg;       // Standalone bit and address copy
  logic                 rst_seen_reg;   // Low until the first edge after reset
  logic [NUM_PORTS-1:0] pon, pgood, strt, cls_fault;
  logic [3:0]           cls [NUM_PORTS];
  logic [3:0]           det [NUM_PORTS];
  logic [NUM_PORTS-1:0] auto_on;
  logic [NUM_PORTS-1:0] turn_on;
  logic                 strt_clr;
  logic [7:0]           rd_mux;

  // Read of 09h clears the start-fault flags
  assign strt_clr = i_rd && (i_cmd == CMD_START_COR);

  genvar g;
  generate
    for (g = 0; g < NUM_PORTS; g++) begin : g_port
      // Auto mode powers a port after a clean valid detect and class
      assign auto_on[g] = (modes_reg[2*g +: 2] == PSPSM_MODE_AUTO) && !pon[g] &&
                          det[g] == DET_VALID && cls[g] != CLS_UNKNOWN &&
                          !cls_fault[g] && dcen_reg[CLE_LSB+g];
      // Host power enable still works after a fault, off mode never powers
      assign turn_on[g] = (auto_on[g] || i_host_power_on[g]) &&
                          modes_reg[2*g +: 2] != PSPSM_MODE_OFF;
      pspsm_port_slot u_slot (
        .i_clk           (i_clk),
        .i_sys_rst       (i_sys_rst),
        .i_det_valid     (i_det_valid[g]),
        .i_det_code      (i_det_code[4*g +: 4]),
        .i_legacy        (i_legacy[g]),
        .i_cls1_valid    (i_cls1_valid[g]),
        .i_cls1_code     (i_cls1_code[4*g +: 4]),
        .i_cls2_valid    (i_cls2_valid[g]),
        .i_cls2_code     (i_cls2_code[4*g +: 4]),
        .i_two_event     (i_two_event[g]),
        .i_turn_on       (turn_on[g]),
        .i_turn_off      (i_turn_off[g]),
        .i_on_done       (i_on_done[g]),
        .i_drain_good    (i_drain_good[g]),
        .i_strt_clear    (strt_clr),
        .o_class_reg     (cls[g]),
        .o_detect_reg    (det[g]),
        .o_pon_reg       (pon[g]),
        .o_pgood_reg     (pgood[g]),
        .o_strt_reg      (strt[g]),
        .o_cls_fault_reg (cls_fault[g])
      );
    end
  endgenerate

  // Reset contents chosen by the standalone bit, taken after release
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      rst_seen_reg <= 1'b0;
    end else begin
      rst_seen_reg <= 1'b1;
    end
  end

  // Address register: caught once after reset, never written by the bus
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      addr_reg <= 8'h00;
    end else if (!rst_seen_reg) begin
      addr_reg <= {i_nv_standalone, i_nv_bus_device_address};
    end
  end

  // Mode register; first edge after reset loads the default chosen by the standalone bit
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      modes_reg <= MODES_HOST_RST;
    end else if (!rst_seen_reg) begin
      modes_reg <= i_nv_standalone ? MODES_AUTO_RST : MODES_HOST_RST;
    end else if (i_wr && i_cmd == CMD_OP_MODES) begin
      modes_reg <= i_wdata;
    end
  end

  // Enable register; turn-off of a port clears its two bits, but a bus write in the same cycle wins
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      dcen_reg <= DCEN_HOST_RST;
    end else if (!rst_seen_reg) begin
      dcen_reg <= i_nv_standalone ? DCEN_AUTO_RST : DCEN_HOST_RST;
    end else if (i_wr && i_cmd == CMD_DC_ENABLE) begin
      dcen_reg <= i_wdata;
    end else begin
      dcen_reg <= dcen_reg & ~{i_turn_off, i_turn_off};
    end
  end

  // Read decode; writes to read-only codes have no path in, so they vanish
  always_comb begin
    case (i_cmd)
      CMD_P1_RESULT:   rd_mux = {cls[0], det[0]};
      CMD_P2_RESULT:   rd_mux = {cls[1], det[1]};
      CMD_P3_RESULT:   rd_mux = {cls[2], det[2]};
      CMD_P4_RESULT:   rd_mux = {cls[3], det[3]};
      CMD_POWER_FLAGS: rd_mux = {pgood, pon};
      CMD_BUS_ADDR:    rd_mux = addr_reg;
      CMD_OP_MODES:    rd_mux = modes_reg;
      CMD_DC_ENABLE:   rd_mux = dcen_reg;
      CMD_START_RO:    rd_mux = {4'h0, strt};
      CMD_START_COR:   rd_mux = {4'h0, strt};
      default:         rd_mux = 8'h00;
    endcase
  end

  // Registered outputs
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_rdata         <= 8'h00;
      o_modes         <= 8'h00;
      o_dc_enable     <= 8'h00;
      o_auto_det_cls  <= 4'h0;
      o_power_request <= 4'h0;
    end else begin
      o_rdata     <= rd_mux;
      o_modes     <= modes_reg;
      o_dc_enable <= dcen_reg;
      for (int i = 0; i < NUM_PORTS; i++) begin
        // Semi-auto and auto automate detect and class
        o_auto_det_cls[i] <= modes_reg[2*i+1];
      end
      o_power_request <= pon;
    end
  end

  // Result read returns the live fields
  property p_res_read;
    @(posedge i_clk) disable iff (i_sys_rst)
      (i_cmd == CMD_P3_RESULT) |=> (o_rdata == $past({cls[2], det[2]}));
  endproperty
  a_res_read: assert property (p_res_read) else $error("port 3 result read wrong");

  // Power status layout
  property p_pwr_read;
    @(posedge i_clk) disable iff (i_sys_rst)
      (i_cmd == CMD_POWER_FLAGS) |=> (o_rdata == $past({pgood, pon}));
  endproperty
  a_pwr_read: assert property (p_pwr_read) else $error("power status read wrong");

  // Address register never follows a bus write
  property p_addr_ro;
    @(posedge i_clk) disable iff (i_sys_rst)
      rst_seen_reg |=> $stable(addr_reg);
  endproperty
  a_addr_ro: assert property (p_addr_ro) else $error("address register changed");

  // Mode write lands one edge later
  property p_mode_wr;
    @(posedge i_clk) disable iff (i_sys_rst)
      (rst_seen_reg && i_wr && i_cmd == CMD_OP_MODES) |=> (modes_reg == $past(i_wdata));
  endproperty
  a_mode_wr: assert property (p_mode_wr) else $error("mode write lost");

  // Off mode never turns a port on
  property p_off_mode;
    @(posedge i_clk) disable iff (i_sys_rst)
      (modes_reg[1:0] == PSPSM_MODE_OFF && !pon[0]) |=> !pon[0];
  endproperty
  a_off_mode: assert property (p_off_mode) else $error("off mode port powered");

  // Fault blocks automatic power-on
  property p_no_auto;
    @(posedge i_clk) disable iff (i_sys_rst)
      (cls_fault[2] && !i_host_power_on[2] && !pon[2]) |=> !pon[2];
  endproperty
  a_no_auto: assert property (p_no_auto) else $error("auto power after class fault");

endmodule // pspsm_regs

// ### include/pspsm_pkg.sv
package pspsm_pkg;

  // Port count and register widths
  localparam int unsigned NUM_PORTS      = 4;
  localparam int unsigned CMD_W          = 8;
  localparam int unsigned DATA_W         = 8;

  // Command codes
  localparam logic [7:0] CMD_P1_RESULT   = 8'h0C;
  localparam logic [7:0] CMD_P2_RESULT   = 8'h0D;
  localparam logic [7:0] CMD_P3_RESULT   = 8'h0E;
  localparam logic [7:0] CMD_P4_RESULT   = 8'h0F;
  localparam logic [7:0] CMD_POWER_FLAGS = 8'h10;
  localparam logic [7:0] CMD_BUS_ADDR    = 8'h11;
  localparam logic [7:0] CMD_OP_MODES    = 8'h12;
  localparam logic [7:0] CMD_DC_ENABLE   = 8'h14;
  localparam logic [7:0] CMD_START_RO    = 8'h08;
  localparam logic [7:0] CMD_START_COR   = 8'h09;

  // Field positions
  localparam int unsigned CLASS_LSB      = 4;
  localparam int unsigned DETECT_LSB     = 0;
  localparam int unsigned PGOOD_LSB      = 4;
  localparam int unsigned PON_LSB        = 0;
  localparam int unsigned STANDALONE_BIT = 7;
  localparam int unsigned CLE_LSB        = 4;
  localparam int unsigned DETE_LSB       = 0;
  localparam int unsigned STRT_LSB       = 0;

  // Reset values
  localparam logic [7:0] RESULT_RST      = 8'h00;
  localparam logic [7:0] POWER_RST       = 8'h00;
  localparam logic [7:0] MODES_AUTO_RST  = 8'hFF;
  localparam logic [7:0] MODES_HOST_RST  = 8'h00;
  localparam logic [7:0] DCEN_AUTO_RST   = 8'hFF;
  localparam logic [7:0] DCEN_HOST_RST   = 8'h00;

  // Classification codes
  localparam logic [3:0] CLS_UNKNOWN     = 4'h0;
  localparam logic [3:0] CLS_RSVD5       = 4'h5;
  localparam logic [3:0] CLS_CLASS0      = 4'h6;
  localparam logic [3:0] CLS_OVERCUR     = 4'h7;
  localparam logic [3:0] CLS_MISMATCH    = 4'h8;

  // Detection codes
  localparam logic [3:0] DET_UNKNOWN     = 4'h0;
  localparam logic [3:0] DET_VALID       = 4'h4;
  localparam logic [3:0] DET_FET_FAULT   = 4'h8;
  localparam logic [3:0] DET_LEGACY_LO   = 4'h9;
  localparam logic [3:0] DET_LEGACY_HI   = 4'hC;

  // Operating modes
  typedef enum logic [1:0] {
    PSPSM_MODE_OFF    = 2'b00,
    PSPSM_MODE_MANUAL = 2'b01,
    PSPSM_MODE_SEMI   = 2'b10,
    PSPSM_MODE_AUTO   = 2'b11
  } pspsm_mode_t;

endpackage

// ### test/pspsm_host_model.sv
`timescale 1ns/1ps
// Host controller model: single-byte command accesses to the bank
module pspsm_host_model #(
  parameter int unsigned MODE_EN_GAP = 120000  // Cycles from a mode write to an enable write
) (
  // Clock
  input  wire logic                        i_clk,
  // Read data from the bank
  input  wire logic [pspsm_pkg::DATA_W-1:0] i_rdata,
  // Command strobes and payload
  output logic                             o_wr,
  output logic                             o_rd,
  output logic [pspsm_pkg::CMD_W-1:0]      o_cmd,
  output logic [pspsm_pkg::DATA_W-1:0]     o_wdata
);
  import pspsm_pkg::*;

  int unsigned cyc       = 0;     // Free cycle count
  int unsigned mode_cyc  = 0;     // Cycle of the last mode write
  logic        mode_seen = 1'b0;  // A mode write has been made

  // Idle bus at time zero
  initial begin
    o_wr    = 1'b0;
    o_rd    = 1'b0;
    o_cmd   = 8'h00;
    o_wdata = 8'h00;
  end

  // Cycle count for the mode-to-enable spacing
  always @(posedge i_clk) cyc <= cyc + 1;

  // Write one byte; enable writes wait out the mode processing delay
  task automatic write_reg(input logic [7:0] cmd, input logic [7:0] data);
    if (cmd === CMD_DC_ENABLE && mode_seen) begin
      while (cyc - mode_cyc < MODE_EN_GAP) @(posedge i_clk);
      #1;
    end
    o_cmd   = cmd;
    o_wdata = data;
    o_wr    = 1'b1;
    @(posedge i_clk);
    #1;
    o_wr    = 1'b0;
    // Released bus shows the inverse so a stale value cannot pass
    o_cmd   = ~cmd;
    o_wdata = ~data;
    if (cmd === CMD_OP_MODES) begin
      mode_cyc  = cyc;
      mode_seen = 1'b1;
    end
    // Idle edge keeps back-to-back calls from retoggling the strobe
    @(posedge i_clk);
    #1;
  endtask

  // Read one byte; data is taken at the edge that ends the strobe
  task automatic read_reg(input logic [7:0] cmd, output logic [7:0] data);
    o_cmd = cmd;
    o_rd  = 1'b1;
    @(posedge i_clk);
    #1;
    data  = i_rdata;
    o_rd  = 1'b0;
    o_cmd = ~cmd;
    // Idle edge between transfers
    @(posedge i_clk);
    #1;
  endtask

  // Stop detection by clearing the enable bit, not by a port-off
  task automatic stop_detect(input int p);
    logic [7:0] d;
    read_reg(CMD_DC_ENABLE, d);
    d[DETE_LSB + p] = 1'b0;
    write_reg(CMD_DC_ENABLE, d);
  endtask

  // Switch a port off unless it shows power on without power good
  task automatic mode_off(input int p);
    logic [7:0] pf;
    logic [7:0] m;
    read_reg(CMD_POWER_FLAGS, pf);
    if (pf[PON_LSB + p] && !pf[PGOOD_LSB + p]) return;
    read_reg(CMD_OP_MODES, m);
    m[2*p +: 2] = PSPSM_MODE_OFF;
    write_reg(CMD_OP_MODES, m);
  endtask
endmodule  // pspsm_host_model

// ### test/pspsm_regs_tb.sv
`timescale 1ns/1ps
// Self-checking bench for the port status and mode register bank
module pspsm_regs_tb;
  import pspsm_pkg::*;
  localparam int unsigned GAP   = 50;    // Short mode-to-enable gap keeps the run brief
  localparam int unsigned LIMIT = 6000;  // Cycle ceiling for the whole run
  // Address clear of the broadcast and alert codes
  localparam logic [6:0]  DEV_ADDR = 7'h2A;

  logic        i_clk = 1'b0, i_sys_rst = 1'b1, nv_sa = 1'b0;
  logic        wr, rd;
  logic [7:0]  cmd, wdata, rdata, modes, dc_en;
  logic [3:0]  det_v = '0, legacy = '0, c1_v = '0, c2_v = '0, two = '0;
  logic [15:0] det_c = '0, c1_c = '0, c2_c = '0;
  logic [3:0]  pon = '0, toff = '0, done = '0, dgood = '0, auto_p, preq;
  logic [7:0]  ro_exp [4];  // Expected read-only contents
  logic [7:0]  ro_cmd [4] = '{CMD_P3_RESULT, CMD_P4_RESULT, CMD_POWER_FLAGS, CMD_BUS_ADDR};
  logic [7:0]  d;
  int          err_count = 0, checks = 0, cycles = 0;

  // Free-running clock
  always #5 i_clk = ~i_clk;

  pspsm_regs DUT (
    .i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_nv_bus_device_address(DEV_ADDR),
    .i_nv_standalone(nv_sa), .i_wr(wr), .i_rd(rd), .i_cmd(cmd), .i_wdata(wdata),
    .i_det_valid(det_v), .i_det_code(det_c), .i_legacy(legacy), .i_cls1_valid(c1_v),
    .i_cls1_code(c1_c), .i_cls2_valid(c2_v), .i_cls2_code(c2_c), .i_two_event(two),
    .i_host_power_on(pon), .i_turn_off(toff), .i_on_done(done), .i_drain_good(dgood),
    .o_rdata(rdata), .o_modes(modes), .o_dc_enable(dc_en), .o_auto_det_cls(auto_p),
    .o_power_request(preq));

  pspsm_host_model #(.MODE_EN_GAP(GAP)) host (
    .i_clk(i_clk), .i_rdata(rdata), .o_wr(wr), .o_rd(rd), .o_cmd(cmd), .o_wdata(wdata));

  // Closing report
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", checks, err_count);
    if (err_count == 0 && checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // Hang guard
  always @(posedge i_clk) begin
    cycles++;
    if (cycles == LIMIT) begin
      err_count++;
      end_of_test();
    end
  end

  // Compare one byte
  task automatic cmp(input string name, input logic [7:0] exp, input logic [7:0] seen);
    checks++;
    if (seen !== exp) begin
      err_count++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // Read a register and compare
  task automatic rchk(input logic [7:0] c, input logic [7:0] exp, input string name);
    host.read_reg(c, d);
    cmp(name, exp, d);
  endtask

  // Reset with a chosen standalone bit; first access three edges after release
  task automatic do_reset(input logic sa);
    i_sys_rst = 1'b1;
    nv_sa     = sa;
    repeat (16) @(posedge i_clk);
    #1 i_sys_rst = 1'b0;
    repeat (3) @(posedge i_clk);
    #1;
  endtask

  // Detection result pulse
  task automatic det_ev(input int p, input logic [3:0] c, input logic leg);
    det_c[4*p +: 4] = c;
    legacy[p]       = leg;
    det_v[p]        = 1'b1;
    @(posedge i_clk);
    #1 det_v[p] = 1'b0;
  endtask

  // Classification: first event, then a second one when two-event is set
  task automatic cls_ev(input int p, input logic [3:0] a, b, input logic t);
    two[p] = t;
    c1_c[4*p +: 4] = a;
    c1_v[p] = 1'b1;
    @(posedge i_clk);
    #1 c1_v[p] = 1'b0;
    if (t) begin
      c2_c[4*p +: 4] = b;
      c2_v[p] = 1'b1;
      @(posedge i_clk);
      #1 c2_v[p] = 1'b0;
    end
  endtask

  // Power sequencing pulses for one port
  task automatic pwr(input int p, input logic on, input logic dn, input logic off);
    pon[p]  = on;
    done[p] = dn;
    toff[p] = off;
    @(posedge i_clk);
    #1;
    pon  = '0;
    done = '0;
    toff = '0;
    // Idle edge: registered outputs settle, next pulse starts clean
    @(posedge i_clk);
    #1;
  endtask

  initial begin
    // Reset contents, host-managed start
    do_reset(1'b0);
    rchk(CMD_P3_RESULT, RESULT_RST, "p3 result");
    rchk(CMD_P4_RESULT, RESULT_RST, "p4 result");
    rchk(CMD_POWER_FLAGS, POWER_RST, "power flags");
    rchk(CMD_BUS_ADDR, {1'b0, DEV_ADDR}, "bus address");
    rchk(CMD_OP_MODES, MODES_HOST_RST, "modes");
    rchk(CMD_DC_ENABLE, DCEN_HOST_RST, "dc enable");
    rchk(8'h30, 8'h00, "unmapped");
    ro_exp = '{RESULT_RST, RESULT_RST, POWER_RST, {1'b0, DEV_ADDR}};
    // Writes to read-only places must leave them as they were
    for (int i = 0; i < 4; i++) begin
      host.write_reg(ro_cmd[i], 8'hA5);
      rchk(ro_cmd[i], ro_exp[i], "read-only reg");
    end
    $display("test reset_values done");

    // Every mode code on some port, in two arrangements
    host.write_reg(CMD_OP_MODES, 8'hE4);
    rchk(CMD_OP_MODES, 8'hE4, "modes");
    cmp("auto ports", 8'h0C, {4'h0, auto_p});
    host.write_reg(CMD_OP_MODES, 8'h1B);
    cmp("modes out", 8'h1B, modes);
    cmp("auto ports", 8'h03, {4'h0, auto_p});
    host.write_reg(CMD_OP_MODES, 8'h55);
    $display("test modes done");

    // Detection codes on port 4, legacy codes gated by the legacy flag
    for (int c = 0; c < 9; c++) begin
      det_ev(3, 4'(c), 1'b0);
      rchk(CMD_P4_RESULT, {4'h0, 4'(c)}, "p4 detect");
    end
    det_ev(3, DET_LEGACY_LO, 1'b0);
    rchk(CMD_P4_RESULT, {4'h0, DET_FET_FAULT}, "p4 detect");
    det_ev(3, DET_LEGACY_LO, 1'b1);
    rchk(CMD_P4_RESULT, {4'h0, DET_LEGACY_LO}, "p4 detect");
    det_ev(3, DET_LEGACY_HI, 1'b1);
    rchk(CMD_P4_RESULT, {4'h0, DET_LEGACY_HI}, "p4 detect");
    $display("test detect_codes done");

    // Single-event class codes on port 3; code 5 reads as class 0
    for (int c = 0; c < 9; c++) begin
      cls_ev(2, 4'(c), 4'h0, 1'b0);
      rchk(CMD_P3_RESULT, {(c == 5) ? CLS_CLASS0 : 4'(c), 4'h0}, "p3 class");
    end
    host.read_reg(CMD_START_COR, d);
    // Two-event outcomes: differing, equal, second overcurrent
    cls_ev(2, 4'h1, 4'h2, 1'b1);
    rchk(CMD_P3_RESULT, {CLS_MISMATCH, 4'h0}, "p3 class");
    rchk(CMD_START_RO, 8'h04, "start flags");
    rchk(CMD_START_COR, 8'h04, "start flags");
    rchk(CMD_START_RO, 8'h00, "start flags");
    cls_ev(2, 4'h3, 4'h3, 1'b1);
    rchk(CMD_P3_RESULT, 8'h30, "p3 class");
    cls_ev(2, 4'h1, CLS_OVERCUR, 1'b1);
    rchk(CMD_P3_RESULT, {CLS_OVERCUR, 4'h0}, "p3 class");
    host.read_reg(CMD_START_COR, d);
    // First overcurrent ends the sequence; the second event is dropped
    cls_ev(3, CLS_OVERCUR, 4'h2, 1'b1);
    rchk(CMD_P4_RESULT, {CLS_OVERCUR, DET_LEGACY_HI}, "p4 class");
    rchk(CMD_START_RO, 8'h08, "start flags");
    $display("test classification done");

    // Power flags: on, good latched, cleared with results at turn-off
    pwr(3, 1'b1, 1'b0, 1'b0);
    rchk(CMD_POWER_FLAGS, 8'h08, "power flags");
    cmp("power request", 8'h08, {4'h0, preq});
    dgood[3] = 1'b1;
    pwr(3, 1'b0, 1'b1, 1'b0);
    dgood[3] = 1'b0;
    rchk(CMD_POWER_FLAGS, 8'h88, "power flags");
    pwr(0, 1'b1, 1'b0, 1'b0);
    pwr(0, 1'b0, 1'b1, 1'b0);
    rchk(CMD_POWER_FLAGS, 8'h89, "power flags");
    host.mode_off(3);
    pwr(3, 1'b0, 1'b0, 1'b1);
    pwr(0, 1'b0, 1'b0, 1'b1);
    rchk(CMD_POWER_FLAGS, 8'h00, "power flags");
    rchk(CMD_P4_RESULT, RESULT_RST, "p4 result");
    $display("test power_flags done");

    // Auto mode: a class fault blocks self power-on, host may still power
    host.write_reg(CMD_OP_MODES, 8'h30);
    host.write_reg(CMD_DC_ENABLE, 8'hFF);
    det_ev(2, DET_VALID, 1'b0);
    cls_ev(2, 4'h1, 4'h2, 1'b1);
    repeat (10) @(posedge i_clk);
    #1 cmp("power request", 8'h00, {4'h0, preq});
    pwr(2, 1'b1, 1'b0, 1'b0);
    cmp("power request", 8'h04, {4'h0, preq});
    pwr(2, 1'b0, 1'b0, 1'b1);
    host.write_reg(CMD_DC_ENABLE, 8'hFF);
    host.stop_detect(0);
    cmp("dc enable out", 8'hFE, dc_en);
    det_ev(2, DET_VALID, 1'b0);
    cls_ev(2, 4'h3, 4'h3, 1'b1);
    for (int k = 0; k < 10 && preq[2] !== 1'b1; k++) begin
      @(posedge i_clk);
      #1;
    end
    cmp("power request", 8'h04, {4'h0, preq});
    $display("test auto_power done");

    // Standalone start: defaults follow the bit, later changes ignored
    do_reset(1'b1);
    rchk(CMD_OP_MODES, MODES_AUTO_RST, "modes");
    rchk(CMD_DC_ENABLE, DCEN_AUTO_RST, "dc enable");
    nv_sa = 1'b0;
    rchk(CMD_BUS_ADDR, {1'b1, DEV_ADDR}, "bus address");
    $display("test standalone done");
    end_of_test();
  end
endmodule  // pspsm_regs_tb
